// file: design/pps_pkg.sv
// Purpose: constants and types for the port pin function select block
// Assumes: 8-bit register port, one clock, synchronous reset
// Notes:   register map and pin bundles shared by design and bench
package pps_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [7:0] PPS_ADDR_P2_LATCH = 8'h00;
    localparam logic [7:0] PPS_ADDR_P2_MODE  = 8'h01;
    localparam logic [7:0] PPS_ADDR_P3_LATCH = 8'h02;
    localparam logic [7:0] PPS_ADDR_P3_MODE  = 8'h03;
    localparam logic [7:0] PPS_ADDR_TRIM     = 8'h04;
    localparam logic [7:0] PPS_ADDR_STATUS   = 8'h05;

    // field positions
    localparam int PPS_TRIM_DIVIDED_CPU_CLOCK_OUTPUT_BIT = 6;
    localparam int PPS_TRIM_FIX0_BIT   = 7;
    localparam int PPS_STAT_FIX1_BIT   = 7;

    // reset values
    localparam logic [3:0] PPS_P2_LATCH_RST = 4'hF;
    localparam logic [1:0] PPS_P3_LATCH_RST = 2'h3;
    localparam logic [5:0] PPS_TRIM_RST     = 6'h20;
    localparam logic [7:0] PPS_RDATA_RST    = 8'h00;

    // pin modes, two bits per pin
    localparam logic [1:0] PPS_MODE_QUASI = 2'h0;
    localparam logic [1:0] PPS_MODE_PUSH  = 2'h1;
    localparam logic [1:0] PPS_MODE_INPUT = 2'h2;
    localparam logic [1:0] PPS_MODE_OPEN  = 2'h3;
    localparam logic [7:0] PPS_P2_MODE_RST = 8'hAA;
    localparam logic [3:0] PPS_P3_MODE_RST = 4'hA;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [1:0] {
        PPS_SRC_RC,
        PPS_SRC_WDT,
        PPS_SRC_EXT,
        PPS_SRC_XTAL
    } pps_src_e;

    typedef struct packed {
        logic o;
        logic oe;
        logic pu;
    } pps_pin_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pps_req_s;

    typedef struct packed {
        logic [3:0] p2_latch;
        logic [7:0] p2_mode;
        logic [1:0] p3_latch;
        logic [3:0] p3_mode;
        logic       clk_out_en;
        logic [5:0] trim;
        logic       clk_div;
        logic [7:0] rdata;
    } pps_state_s;

endpackage : pps_pkg

// file: design/pps_pin_select.sv
// Purpose: steer the upper port 2 pins and the two port 3 pins between
//          port data, the serial unit, the oscillator and the clock output
// Assumes: pin inputs synchronous to mclk, mclk is the cpu clock
// Notes:   pin outputs are o/oe/pu bundles; the pad resolves the wire
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps

module pps_pin_select
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // register port
    input  wire pps_pkg::pps_req_s req,
    output      logic [7:0]       rdata,
    // clock configuration
    input  wire pps_pkg::pps_src_e nv_osc_sel,
    input  wire pps_pkg::pps_src_e cpu_clk_src,
    input  wire logic             rtc_on_crystal,
    input  wire logic             osc_amp_out,
    output      logic             crystal_input_pin,
    // serial unit
    input  wire logic             serial_enable,
    input  wire logic             serial_is_master,
    input  wire logic             mosi_from_spi,
    input  wire logic             miso_from_spi,
    input  wire logic             sck_from_spi,
    output      logic             mosi_to_spi,
    output      logic             miso_to_spi,
    output      logic             sck_to_spi,
    output      logic             select_to_spi,
    // port 2 upper pins
    input  wire logic [3:0]       port2_in,
    output      pps_pkg::pps_pin_s port2_bit2,
    output      pps_pkg::pps_pin_s port2_bit3,
    output      pps_pkg::pps_pin_s port2_bit4,
    output      pps_pkg::pps_pin_s serial_iface_clock_pin,
    // port 3 pins and oscillator trim
    input  wire logic [1:0]       port3_in,
    output      pps_pkg::pps_pin_s port3_bit0,
    output      pps_pkg::pps_pin_s port3_bit1,
    output      logic [5:0]       osc_trim
);
    import pps_pkg::*;

    // ********************************************************
    // state
    // ********************************************************
    pps_state_s st;
    pps_state_s next_st;
    logic       divided_cpu_clock_output_ok;
    logic       p3b0_amp;
    logic       p3b0_clk;
    logic       p3b1_osc;
    logic [7:0] status_word;

    // port driver for one pin from its mode and latch
    function automatic pps_pin_s port_drive(input logic [1:0] mode,
                                            input logic       latch);
        pps_pin_s p;
        p.o  = latch;
        p.oe = 1'b0;
        p.pu = 1'b0;
        case (mode)
            PPS_MODE_QUASI:
            begin
                p.oe = ~latch;
                p.pu = 1'b1;
            end
            PPS_MODE_PUSH:  p.oe = 1'b1;
            PPS_MODE_OPEN:  p.oe = ~latch;
            default:        p.oe = 1'b0;
        endcase
        return p;
    endfunction : port_drive

    // ********************************************************
    // clock source decisions
    // ********************************************************
    // clock output gate
    assign divided_cpu_clock_output_ok = (cpu_clk_src != PPS_SRC_XTAL) && !rtc_on_crystal;
    assign p3b0_amp  = (nv_osc_sel == PPS_SRC_XTAL) || rtc_on_crystal;
    assign p3b0_clk  = !p3b0_amp && st.clk_out_en && divided_cpu_clock_output_ok;
    assign p3b1_osc  = (nv_osc_sel == PPS_SRC_XTAL)
                    || (nv_osc_sel == PPS_SRC_EXT)
                    || (cpu_clk_src == PPS_SRC_EXT)
                    || (cpu_clk_src == PPS_SRC_XTAL)
                    || rtc_on_crystal;

    // status word, fixed-one bit on top
    assign status_word = {1'b1, 1'b0, port3_in, p3b1_osc, p3b0_clk,
                          p3b0_amp, serial_is_master};

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        next_st = st;
        // divided clock toggles every rising edge
        next_st.clk_div = ~st.clk_div;
        if (req.wr)
        begin
            case (req.addr)
                PPS_ADDR_P2_LATCH: next_st.p2_latch = req.wdata[5:2];
                PPS_ADDR_P2_MODE:  next_st.p2_mode  = req.wdata;
                PPS_ADDR_P3_LATCH: next_st.p3_latch = req.wdata[1:0];
                // each pin owns two mode bits
                PPS_ADDR_P3_MODE:  next_st.p3_mode  = req.wdata[3:0];
                PPS_ADDR_TRIM:
                begin
                    next_st.clk_out_en = req.wdata[PPS_TRIM_DIVIDED_CPU_CLOCK_OUTPUT_BIT];
                    next_st.trim       = req.wdata[5:0];
                end
                default: next_st.p2_latch = st.p2_latch;
            endcase
        end
        next_st.rdata = 8'h00;
        if (req.rd)
        begin
            // reserved and zero bits read zero
            case (req.addr)
                PPS_ADDR_P2_LATCH:
                    next_st.rdata = {2'b00, st.p2_latch, 2'b00};
                PPS_ADDR_P2_MODE:  next_st.rdata = st.p2_mode;
                PPS_ADDR_P3_LATCH: next_st.rdata = {6'h00, st.p3_latch};
                PPS_ADDR_P3_MODE:  next_st.rdata = {4'h0, st.p3_mode};
                PPS_ADDR_TRIM:
                    next_st.rdata = {1'b0, st.clk_out_en, st.trim};
                PPS_ADDR_STATUS:   next_st.rdata = status_word;
                default:           next_st.rdata = 8'h00;
            endcase
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.p2_latch <= PPS_P2_LATCH_RST;
            st.p2_mode  <= PPS_P2_MODE_RST;
            st.p3_latch <= PPS_P3_LATCH_RST;
            st.p3_mode  <= PPS_P3_MODE_RST;
            st.trim     <= PPS_TRIM_RST;
            st.rdata    <= PPS_RDATA_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata    = st.rdata;
    assign osc_trim = st.trim;

    // ********************************************************
    // port 2 pins
    // ********************************************************
    always_comb
    begin
        port2_bit2 = port_drive(st.p2_mode[1:0], st.p2_latch[0]);
        port2_bit3 = port_drive(st.p2_mode[3:2], st.p2_latch[1]);
        port2_bit4 = port_drive(st.p2_mode[5:4], st.p2_latch[2]);
        serial_iface_clock_pin = port_drive(st.p2_mode[7:6],
                                            st.p2_latch[3]);
        if (serial_enable)
        begin
            port2_bit2.o  = mosi_from_spi;
            port2_bit2.oe = serial_is_master;
            port2_bit2.pu = 1'b0;
            port2_bit3.o  = miso_from_spi;
            port2_bit3.oe = !serial_is_master;
            port2_bit3.pu = 1'b0;
            serial_iface_clock_pin.o  = sck_from_spi;
            serial_iface_clock_pin.oe = serial_is_master;
            serial_iface_clock_pin.pu = 1'b0;
        end
    end

    // pin levels back to the serial unit
    assign mosi_to_spi   = port2_in[0];
    assign miso_to_spi   = port2_in[1];
    assign select_to_spi = port2_in[2];
    assign sck_to_spi    = port2_in[3];

    // ********************************************************
    // port 3 pins
    // ********************************************************
    always_comb
    begin
        port3_bit0 = port_drive(st.p3_mode[1:0], st.p3_latch[0]);
        port3_bit1 = port_drive(st.p3_mode[3:2], st.p3_latch[1]);
        if (p3b0_amp)
        begin
            port3_bit0 = '{o: osc_amp_out, oe: 1'b1, pu: 1'b0};
        end
        else if (p3b0_clk)
        begin
            port3_bit0 = '{o: st.clk_div, oe: 1'b1, pu: 1'b0};
        end
        if (p3b1_osc)
        begin
            port3_bit1 = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
        end
    end

    // oscillator input is the bit 1 level when claimed
    assign crystal_input_pin = p3b1_osc & port3_in[1];

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence trim_wr_en;
        req.wr && req.addr == PPS_ADDR_TRIM
            && req.wdata[PPS_TRIM_DIVIDED_CPU_CLOCK_OUTPUT_BIT];
    endsequence

    mosi_dir_a: assert property (serial_enable |->
        port2_bit2.oe == serial_is_master)
        else $error("mosi direction wrong");
    miso_dir_a: assert property (serial_enable |->
        port2_bit3.oe == !serial_is_master)
        else $error("miso direction wrong");
    sck_dir_a: assert property (serial_enable && serial_is_master |->
        serial_iface_clock_pin.oe && serial_iface_clock_pin.o == sck_from_spi)
        else $error("serial clock not driven");
    p3_reset_a: assert property (disable iff (1'b0)
        sys_rst |=> st.p3_mode == PPS_P3_MODE_RST && !port3_bit0.pu)
        else $error("port 3 not input-only after reset");
    p3_indep_a: assert property (req.wr && req.addr == PPS_ADDR_P3_MODE
        |=> st.p3_mode[3:2] == $past(req.wdata[3:2])
            && st.p3_mode[1:0] == $past(req.wdata[1:0]))
        else $error("port 3 mode bits mixed");
    divided_cpu_clock_output_a: assert property (trim_wr_en ##1 (!p3b0_amp && divided_cpu_clock_output_ok)
        |-> port3_bit0.oe && port3_bit0.o == st.clk_div)
        else $error("clock output missing");
    clk_toggle_a: assert property (p3b0_clk [*2]
        |-> port3_bit0.o != $past(port3_bit0.o))
        else $error("clock output not divided by two");
    divided_cpu_clock_output_block_a: assert property (cpu_clk_src == PPS_SRC_XTAL
        && nv_osc_sel != PPS_SRC_XTAL && !rtc_on_crystal
        |-> port3_bit0 == port_drive(st.p3_mode[1:0], st.p3_latch[0]))
        else $error("clock output while blocked");
    amp_out_a: assert property (p3b0_amp |->
        port3_bit0.oe && port3_bit0.o == osc_amp_out)
        else $error("amplifier output missing");
    osc_in_a: assert property (nv_osc_sel == PPS_SRC_EXT |->
        !port3_bit1.oe && crystal_input_pin == port3_in[1])
        else $error("oscillator input not fed");
    status_one_a: assert property (req.rd && req.addr == PPS_ADDR_STATUS
        |=> rdata[PPS_STAT_FIX1_BIT])
        else $error("fixed-one bit reads zero");
    trim_zero_a: assert property (req.rd && req.addr == PPS_ADDR_TRIM
        |=> !rdata[PPS_TRIM_FIX0_BIT])
        else $error("fixed-zero bit reads one");

endmodule : pps_pin_select

// file: tb/pps_peer_model.sv
// Purpose: far side of the pins: serial peer, crystal and pad wires
// Assumes: the bench picks which released pins the peer drives
// Notes:   an undriven line without pull-up flips every cycle
`timescale 1ns/100ps

module pps_peer_model
(
    // clock
    input  wire logic                  mclk,
    // pins: port2 bits 2..5 at 3:0, port3 bits 0..1 at 5:4
    input  wire pps_pkg::pps_pin_s [5:0] pins,
    input  wire logic [5:0]            peer_en,
    input  wire logic [5:0]            peer_val,
    // resolved wires and crystal amplifier
    output      logic [5:0]            level,
    output      logic                  osc_amp_out
);
    import pps_pkg::*;
    // ****************************************************
    // wire resolution
    // ****************************************************
    logic [5:0] last    = 6'h00;
    logic [1:0] amp_cnt = 2'h0;
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            level[i] = pins[i].oe ? pins[i].o :
                       peer_en[i] ? peer_val[i] : pins[i].pu | ~last[i];
        end
    end
    // history of wires, crystal runs at a third of mclk
    always_ff @(posedge mclk)
    begin
        last    <= level;
        amp_cnt <= (amp_cnt == 2'h2) ? 2'h0 : amp_cnt + 2'h1;
    end
    assign osc_amp_out = amp_cnt[1];
endmodule : pps_peer_model

// file: tb/port_pin_function_select_tb.sv
// Purpose: self-checking bench for the pin function select block
// Assumes: register port at 100 MHz, model kept in plain variables
// Notes:   random roles, clock sources and register writes
`timescale 1ns/100ps

module port_pin_function_select_tb;
    import pps_pkg::*;
    // ****************************************************
    // signals and model state
    // ****************************************************
    logic       mclk, sys_rst, rtc, sen, master, mosi_f, miso_f, sck_f;
    logic       cin, mosi_t, miso_t, sck_t, sel_t, amp_o, prev;
    pps_req_s   req;
    pps_src_e   nv, cpu;
    logic [7:0] rdata, m_p2m, m_trim;
    logic [5:0] peer_val, trim_o;
    logic [3:0] m_p2l, m_p3m;
    logic [1:0] m_p3l;
    wire logic  [5:0] level, peer_en;
    wire pps_pin_s [5:0] pins;
    wire logic  amp, osc1, ck;
    int         mismatches, tests_run;
    integer     seed = 32'h6609_8a94;
    assign amp  = nv == PPS_SRC_XTAL || rtc;
    assign osc1 = nv >= PPS_SRC_EXT || cpu >= PPS_SRC_EXT || rtc;
    assign ck   = m_trim[6] && cpu != PPS_SRC_XTAL && !rtc;
    assign peer_en = {osc1, 1'b0, ~master, 1'b0, master, ~master};

    pps_pin_select u_dut (.mclk(mclk), .sys_rst(sys_rst), .req(req),
        .rdata(rdata), .nv_osc_sel(nv), .cpu_clk_src(cpu),
        .rtc_on_crystal(rtc), .osc_amp_out(amp_o),
        .crystal_input_pin(cin), .serial_enable(sen),
        .serial_is_master(master), .mosi_from_spi(mosi_f),
        .miso_from_spi(miso_f), .sck_from_spi(sck_f),
        .mosi_to_spi(mosi_t), .miso_to_spi(miso_t), .sck_to_spi(sck_t),
        .select_to_spi(sel_t), .port2_in(level[3:0]),
        .port2_bit2(pins[0]), .port2_bit3(pins[1]), .port2_bit4(pins[2]),
        .serial_iface_clock_pin(pins[3]), .port3_in(level[5:4]),
        .port3_bit0(pins[4]), .port3_bit1(pins[5]), .osc_trim(trim_o));
    pps_peer_model u_peer (.mclk(mclk), .pins(pins), .peer_en(peer_en),
        .peer_val(peer_val), .level(level), .osc_amp_out(amp_o));

    // clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ****************************************************
    // compare tasks and model
    // ****************************************************
    task automatic chk_pin(input pps_pin_s g, input logic [2:0] e, k);
        tests_run++;
        if ((g & k) !== (e & k))
        begin
            mismatches++;
            $display("mismatch at %0t: pin %b exp %b", $time, g, e);
        end
    endtask : chk_pin
    task automatic chk_reg(input logic [7:0] g, e, k);
        tests_run++;
        if ((g & k) !== (e & k))
        begin
            mismatches++;
            $display("mismatch at %0t: value %h exp %h", $time, g, e);
        end
    endtask : chk_reg
    task automatic tally_and_finish;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset(input int n);
        sys_rst <= 1'b1;
        repeat (n) @(posedge mclk);
        sys_rst <= 1'b0;
        {m_p2l, m_p2m, m_p3l, m_p3m, m_trim} = {4'hF, 8'hAA, 2'h3, 4'hA,
                                                8'h20};
    endtask : do_reset
    task automatic reg_wr(input logic [7:0] a, d);
        @(posedge mclk);
        req <= {a, d, 2'b10};
        @(posedge mclk);
        req.wr <= 1'b0;
        case (a)
            8'h00: m_p2l = d[5:2];
            8'h01: m_p2m = d;
            8'h02: m_p3l = d[1:0];
            8'h03: m_p3m = d[3:0];
            8'h04: m_trim = d;
            default: ;
        endcase
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        logic [7:0] e;
        @(posedge mclk);
        req <= {a, 8'h00, 2'b01};
        // expectation taken while the strobe stands, before the edge
        @(negedge mclk);
        case (a)
            8'h00: e = {2'h0, m_p2l, 2'h0};
            8'h01: e = m_p2m;
            8'h02: e = {6'h00, m_p3l};
            8'h03: e = {4'h0, m_p3m};
            8'h04: e = {1'b0, m_trim[6:0]};
            8'h05: e = {2'b10, level[5:4], osc1, ck, amp, master};
            default: e = 8'h00;
        endcase
        @(posedge mclk);
        req.rd <= 1'b0;
        @(negedge mclk);
        chk_reg(rdata, e, (a == 8'h05 && amp) ? 8'hFB : 8'hFF);
    endtask : reg_rd
    function automatic logic [2:0] pmask(input logic [1:0] m);
        return {2'b01, m == PPS_MODE_QUASI || m == PPS_MODE_INPUT};
    endfunction : pmask
    function automatic logic [2:0] pexp(input logic [1:0] m, input logic l);
        return {1'b0, m == PPS_MODE_PUSH || (!l && m[0] == m[1]),
                m == PPS_MODE_QUASI};
    endfunction : pexp
    task automatic check_pins;
        logic [2:0] e;
        logic [2:0] k;
        for (int i = 0; i < 4; i++)
        begin
            e = pexp(m_p2m[2*i +: 2], m_p2l[i]);
            k = pmask(m_p2m[2*i +: 2]);
            if (sen && i != 2)
            begin
                e = {i == 0 ? mosi_f : i == 1 ? miso_f : sck_f,
                     (i == 1) ^ master, 1'b0};
                k = {e[1], 2'b11};
            end
            chk_pin(pins[i], e, k);
        end
        e = ck ? 3'b010 : pexp(m_p3m[1:0], m_p3l[0]);
        k = ck ? 3'b010 : pmask(m_p3m[1:0]);
        if (amp)
            chk_pin(pins[4], {amp_o, 2'b10}, 3'b110);
        else
            chk_pin(pins[4], e, k);
        e = osc1 ? 3'b000 : pexp(m_p3m[3:2], m_p3l[1]);
        k = osc1 ? 3'b010 : pmask(m_p3m[3:2]);
        chk_pin(pins[5], e, k);
        chk_reg({7'h00, cin}, {7'h00, osc1 & level[5]}, 8'hFF);
        chk_reg({4'h0, sck_t, sel_t, miso_t, mosi_t}, {4'h0, level[3:0]},
                8'hFF);
        chk_reg({2'h0, trim_o}, {2'h0, m_trim[5:0]}, 8'hFF);
    endtask : check_pins
    // ****************************************************
    // main sequence and watchdog
    // ****************************************************
    initial
    begin
        {sys_rst, rtc, sen, master, mosi_f, miso_f, sck_f} = 7'h40;
        req      = '0;
        peer_val = '0;
        nv       = PPS_SRC_RC;
        cpu      = PPS_SRC_RC;
        {mismatches, tests_run} = '0;
        do_reset(10);
        @(negedge mclk);
        check_pins();
        for (int a = 0; a < 6; a++)
            reg_rd(a[7:0]);
        for (int n = 0; n < 150; n++)
        begin
            @(posedge mclk);
            {rtc, sen, master, mosi_f, miso_f, sck_f} <= 6'($random(seed));
            nv       <= pps_src_e'(2'($random(seed)));
            cpu      <= pps_src_e'(2'($random(seed)));
            peer_val <= 6'($random(seed));
            reg_wr(8'(n % 5), 8'($random(seed)) & (n % 5 == 0 ? 8'h3C
                   : n % 5 == 1 ? 8'hFF : n % 5 == 2 ? 8'h03
                   : n % 5 == 3 ? 8'h0F : 8'h7F));
            @(negedge mclk);
            check_pins();
            reg_rd(8'($unsigned($random(seed)) % 6));
            if (n == 100)
            begin
                // reset raised on a rising edge like every other input
                @(posedge mclk);
                do_reset(2);
            end
        end
        @(posedge mclk);
        nv  <= PPS_SRC_RC;
        cpu <= PPS_SRC_EXT;
        rtc <= 1'b0;
        reg_wr(8'h04, 8'h55);
        @(negedge mclk);
        prev = pins[4].o;
        repeat (8)
        begin
            @(negedge mclk);
            chk_pin(pins[4], {~prev, 2'b10}, 3'b110);
            prev = pins[4].o;
        end
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        tally_and_finish();
    end
endmodule : port_pin_function_select_tb
